// [spfp_consts.svh]
// Purpose: constants of the serial flash read and program sequencer
// Assumes: 25 MHz system clock
// Notes: opcodes, field positions, reset values and timing counts
`ifndef SPFP_CONSTS_SVH
`define SPFP_CONSTS_SVH

// ****************************************
// Opcodes
// ****************************************
`define SPFP_OP_READ_FAST 8'h0B
`define SPFP_OP_READ_SLOW 8'h03
`define SPFP_OP_READ_DUAL 8'h3B
`define SPFP_OP_PROGRAM 8'h02
`define SPFP_OP_STATUS 8'h05
`define SPFP_OP_ACTIVE_STATUS 8'h25
`define SPFP_OP_WRITE_ENABLE 8'h06
`define SPFP_OP_WRITE_DISABLE 8'h04

// ****************************************
// Array and status layout
// ****************************************
`define SPFP_ARRAY_AW 19
`define SPFP_ARRAY_LAST 19'h7FFFF
`define SPFP_STAT_BUSY_BIT 0
`define SPFP_STAT_WEL_BIT 1
`define SPFP_STAT_FAIL_BIT 5
`define SPFP_PAGE_BYTES 9'h100

// ****************************************
// Reset values
// ****************************************
`define SPFP_RST_WEL 1'b0
`define SPFP_RST_FAIL 1'b0
`define SPFP_RST_BYTE 8'h00

// ****************************************
// Timing
// ****************************************
`define SPFP_CLK_MHZ 25
`define SPFP_PAGE_PROGRAM_TIME_US 2000
`define SPFP_BYTE_PROGRAM_TIME_US 8
`define SPFP_BYTE_PROGRAM_CYCLES (`SPFP_BYTE_PROGRAM_TIME_US * `SPFP_CLK_MHZ)
`define SPFP_PAGE_PROGRAM_CYCLES (`SPFP_PAGE_PROGRAM_TIME_US * `SPFP_CLK_MHZ)

`endif

// [spfp_host.sv]
// Purpose: host serial master driving the sequencer pins
// Assumes: mode 0, 320 ns serial clock, paced by system clock
// Notes: samples the data lines just before each falling edge
`timescale 1ns/1ps
module spfp_host (
   input wire logic clock,
   output logic csN,
   output logic sck,
   output logic si,
   input wire logic so,
   input wire logic second_data_line
);
   // ****************************************
   // Frame tasks
   // ****************************************
   // Idle pins at time zero
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // Select, then let the synchronisers settle
   task automatic open_frame();
      @(posedge clock);
      #1 csN = 1'b0;
      repeat (4) @(posedge clock);
   endtask
   // Release select, keep it high long enough to be seen
   task automatic close_frame();
      @(posedge clock);
      #1 csN = 1'b1;
      repeat (8) @(posedge clock);
   endtask
   // Clocks n bits MSB first, two bits a clock when dual
   task automatic shift(input logic [7:0] tx, input int n,
         input logic dual, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         #1 si = tx[7 - i];
         repeat (3) @(posedge clock);
         #1 sck = 1'b1;
         repeat (4) @(posedge clock);
         #1 rx = dual ? {rx[5:0], so, second_data_line} : {rx[6:0], so};
         sck = 1'b0;
      end
   endtask
endmodule

// [spfp_page_buf.sv]
// Purpose: 256-byte page buffer with registered read
// Assumes: one write and one read port on the system clock
// Notes: contents are not reset, only the read register is
`timescale 1ns/1ps
`include "spfp_consts.svh"
module spfp_page_buf (
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic wrEn,
   input wire logic [7:0] wrAddr,
   input wire logic [7:0] wrData,
   input wire logic [7:0] rdAddr,
   output logic [7:0] rdData
);

   logic [7:0] mem [0:255];

   // Storage write
   always_ff @(posedge clock) begin
      if (clkEn && wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdData <= `SPFP_RST_BYTE;
      end else if (clkEn) begin
         rdData <= mem[rdAddr];
      end
   end

endmodule

// [spfp_pkg.sv]
// Purpose: types of the serial flash read and program sequencer
// Assumes: nothing
// Notes: command phases and the array write word
package spfp_pkg;

   // ****************************************
   // Command phase, one-hot
   // ****************************************
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_DUMMY = 9'h004,
      ST_READ = 9'h008,
      ST_PROG = 9'h010,
      ST_STAT = 9'h020,
      ST_ASI = 9'h040,
      ST_HOLD = 9'h080,
      ST_IGNORE = 9'h100
   } spfp_state_t;

   // ****************************************
   // One array write
   // ****************************************
   typedef struct packed {
      logic [18:0] addr;
      logic [7:0] data;
   } spfp_wr_t;

endpackage

// [spfp_sequencer.sv]
// Purpose: serial flash read, dual read, page program and busy report
// Assumes: serial pins asynchronous, array ports on the system clock
// Notes: serial clock sampled at 25 MHz, so it must stay well below
//
// Functional notes
// - accept fast and slow read opcodes
// - three address bytes, dummy for fast and dual, none for slow
// - single read shifts MSB first, address advances
// - address wraps from last byte to zero
// - chip select release tristates output at once
// - dual read takes address and one dummy
// - dual read sends two bits per clock
// - release in dual read tristates both lines
// - program starts only with write enable set
// - program opcode, address, bytes into buffer
// - bytes past page end wrap in page
// - only the last 256 bytes kept
// - program only sent bytes from start address
// - incomplete address or byte aborts program
// - protected target skips program, back idle
// - every program abort clears write enable
// - status read reports busy while programming
// - active status drives output low when done
// - write enable cleared before program finishes
// - failed byte sets program failure flag
// - program self-timed, page or byte time
// - upper five address bits ignored
// - early release performs nothing, back idle
// - unknown opcode ignored until release
`timescale 1ns/1ps
`include "spfp_consts.svh"
module spfp_sequencer #(
   parameter int PAGE_PROG_CYCLES = `SPFP_PAGE_PROGRAM_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic csNPin,
   input wire logic sckPin,
   input wire logic siPin,
   output logic soOut,
   output logic soOe,
   output logic sioOut,
   output logic sioOe,
   output logic [18:0] arrayRdAddr,
   input wire logic [7:0] arrayRdData,
   output spfp_pkg::spfp_wr_t progWord,
   output logic progValid,
   input wire logic progReady,
   input wire logic progFail,
   input wire logic sectorProtected,
   output logic busy,
   output logic writeEnableLatch,
   output logic programFailureFlag
);

   // ****************************************
   // Pin synchronisers and edges
   // ****************************************
   logic csMeta_q, csSync_q, csDly_q;
   logic sckMeta_q, sckSync_q, sckDly_q;
   logic siMeta_q, siSync_q;

   // Two flops per pin, third only for edge finding
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {csMeta_q, csSync_q, csDly_q} <= 3'h7;
         {sckMeta_q, sckSync_q, sckDly_q} <= 3'h0;
         {siMeta_q, siSync_q} <= 2'h0;
      end else if (clkEn) begin
         {csMeta_q, csSync_q, csDly_q} <= {csNPin, csMeta_q, csSync_q};
         {sckMeta_q, sckSync_q, sckDly_q} <= {sckPin, sckMeta_q, sckSync_q};
         {siMeta_q, siSync_q} <= {siPin, siMeta_q};
      end
   end

   wire csActive = !csSync_q;
   wire csRise = csSync_q && !csDly_q;
   wire sckRise = csActive && sckSync_q && !sckDly_q;
   wire sckFall = csActive && !sckSync_q && sckDly_q;

   // ****************************************
   // Input byte assembly
   // ****************************************
   spfp_pkg::spfp_state_t st_q, st_d;
   logic [7:0] inSh_q, op_q;
   logic [2:0] bitCnt_q;
   logic [1:0] addrCnt_q;
   logic [23:0] addrSh_q;
   logic [8:0] pgCnt_q;
   logic [10:0] pgBase_q;
   logic [7:0] pgStartLo_q;
   logic [7:0] wrOff_q;
   logic wel_q, fail_q, busy_q;

   wire [7:0] rxByte = {inSh_q[6:0], siSync_q};
   wire byteDone = sckRise && (bitCnt_q == 3'h7);
   wire [23:0] fullAddr = {addrSh_q[15:0], rxByte};
   wire addrDone = byteDone && (st_q == spfp_pkg::ST_ADDR) &&
                   (addrCnt_q == 2'h2);
   wire isDual = (op_q == `SPFP_OP_READ_DUAL);

   // Phase after an opcode byte
   function automatic spfp_pkg::spfp_state_t opPhase(
      input logic [7:0] op, input logic isBusy, input logic write_enable_latch);
      spfp_pkg::spfp_state_t ph;
      ph = spfp_pkg::ST_IGNORE;
      if (op == `SPFP_OP_STATUS) begin
         ph = spfp_pkg::ST_STAT;
      end else if (op == `SPFP_OP_ACTIVE_STATUS) begin
         ph = spfp_pkg::ST_DUMMY;
      end else if (isBusy) begin
         ph = spfp_pkg::ST_IGNORE;
      end else if (op == `SPFP_OP_READ_FAST || op == `SPFP_OP_READ_SLOW ||
                   op == `SPFP_OP_READ_DUAL) begin
         ph = spfp_pkg::ST_ADDR;
      end else if (op == `SPFP_OP_PROGRAM && write_enable_latch) begin
         ph = spfp_pkg::ST_ADDR;
      end else if (op == `SPFP_OP_WRITE_ENABLE ||
                   op == `SPFP_OP_WRITE_DISABLE) begin
         ph = spfp_pkg::ST_HOLD;
      end
      return ph;
   endfunction

   // Command phase; release always returns to idle
   always_comb begin
      st_d = st_q;
      if (!csActive) begin
         st_d = spfp_pkg::ST_IDLE;
      end else if (byteDone) begin
         unique case (st_q)
            spfp_pkg::ST_IDLE: begin
               st_d = opPhase(rxByte, busy_q, wel_q);
            end
            spfp_pkg::ST_ADDR: begin
               if (addrCnt_q == 2'h2) begin
                  if (op_q == `SPFP_OP_READ_SLOW) begin
                     st_d = spfp_pkg::ST_READ;
                  end else if (op_q == `SPFP_OP_PROGRAM) begin
                     st_d = spfp_pkg::ST_PROG;
                  end else begin
                     st_d = spfp_pkg::ST_DUMMY;
                  end
               end
            end
            spfp_pkg::ST_DUMMY: begin
               st_d = (op_q == `SPFP_OP_ACTIVE_STATUS) ?
                      spfp_pkg::ST_ASI : spfp_pkg::ST_READ;
            end
            spfp_pkg::ST_READ, spfp_pkg::ST_PROG, spfp_pkg::ST_STAT,
            spfp_pkg::ST_ASI, spfp_pkg::ST_HOLD, spfp_pkg::ST_IGNORE: begin
               st_d = st_q;
            end
            default: begin
               st_d = spfp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Shift in, count bits, capture opcode and address
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= spfp_pkg::ST_IDLE;
         inSh_q <= `SPFP_RST_BYTE;
         op_q <= `SPFP_RST_BYTE;
         bitCnt_q <= 3'h0;
         addrCnt_q <= 2'h0;
         addrSh_q <= 24'h000000;
      end else if (clkEn) begin
         st_q <= st_d;
         if (!csActive) begin
            bitCnt_q <= 3'h0;
            addrCnt_q <= 2'h0;
         end else if (sckRise) begin
            inSh_q <= rxByte;
            bitCnt_q <= bitCnt_q + 3'h1;
         end
         if (byteDone && st_q == spfp_pkg::ST_IDLE) begin
            op_q <= rxByte;
         end
         if (byteDone && st_q == spfp_pkg::ST_ADDR) begin
            addrSh_q <= fullAddr;
            addrCnt_q <= addrCnt_q + 2'h1;
         end
      end
   end

   // ****************************************
   // Read and status output path
   // ****************************************
   logic [18:0] rdAddr_q;
   logic [7:0] nextByte_q, outSh_q;
   logic [2:0] outCnt_q;
   logic [1:0] fetch_q;
   logic so_q, soOe_q, sio_q, sioOe_q;

   wire inRead = (st_q == spfp_pkg::ST_READ);
   wire inStat = (st_q == spfp_pkg::ST_STAT);
   wire inAsi = (st_q == spfp_pkg::ST_ASI);
   wire dualOut = inRead && isDual;
   wire [2:0] lastSlot = dualOut ? 3'h3 : 3'h7;
   wire byteStart = (outCnt_q == 3'h0);
   wire [7:0] statusByte = ({7'h00, busy_q} << `SPFP_STAT_BUSY_BIT) |
                           ({7'h00, wel_q} << `SPFP_STAT_WEL_BIT) |
                           ({7'h00, fail_q} << `SPFP_STAT_FAIL_BIT);
   wire [7:0] curByte = !byteStart ? outSh_q :
                        inRead ? nextByte_q : statusByte;
   wire shiftOut = sckFall && (inRead || inStat);
   wire loadRead = shiftOut && inRead && byteStart;
   wire fetchGo = addrDone || loadRead;
   wire [18:0] rdAddr_d = addrDone ? fullAddr[18:0] : rdAddr_q + 19'h1;

   // Address counter and two-cycle array fetch
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdAddr_q <= 19'h00000;
         fetch_q <= 2'h0;
         nextByte_q <= `SPFP_RST_BYTE;
      end else if (clkEn) begin
         if (fetchGo) begin
            rdAddr_q <= rdAddr_d;
         end
         fetch_q <= {fetch_q[0], fetchGo};
         if (fetch_q[1]) begin
            nextByte_q <= arrayRdData;
         end
      end
   end

   // Output shifter, updated on falling serial clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {so_q, soOe_q, sio_q, sioOe_q} <= 4'h0;
         outSh_q <= `SPFP_RST_BYTE;
         outCnt_q <= 3'h0;
      end else if (clkEn) begin
         if (!csActive) begin
            {soOe_q, sioOe_q} <= 2'h0;
            outCnt_q <= 3'h0;
         end else if (shiftOut) begin
            so_q <= curByte[7];
            sio_q <= curByte[6];
            soOe_q <= 1'b1;
            sioOe_q <= dualOut;
            outSh_q <= dualOut ? {curByte[5:0], 2'h0} : {curByte[6:0], 1'b0};
            outCnt_q <= (outCnt_q == lastSlot) ? 3'h0 : outCnt_q + 3'h1;
         end else if (inAsi) begin
            so_q <= busy_q;
            soOe_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // Program command: buffer fill and checks
   // ****************************************
   logic [8:0] pgLeft_q;
   logic [7:0] pgIdx_q;
   logic [15:0] tmr_q;
   logic rdPend_q, vld0_q, vld1_q;
   spfp_pkg::spfp_wr_t e0_q, e1_q;
   wire [7:0] bufRdData;

   wire inProg = (st_q == spfp_pkg::ST_PROG);
   wire progByte = byteDone && inProg;
   wire [7:0] bufWrIdx = pgStartLo_q + wrOff_q;
   wire progEnd = csRise && inProg;
   wire progOk = (pgCnt_q != 9'h000) && (bitCnt_q == 3'h0) &&
                 !sectorProtected;
   wire progStart = progEnd && progOk;
   wire progAbort = (progEnd && !progOk) || (csRise &&
                    st_q == spfp_pkg::ST_ADDR && op_q == `SPFP_OP_PROGRAM);
   wire holdEnd = csRise && (st_q == spfp_pkg::ST_HOLD) &&
                  (bitCnt_q == 3'h0);
   wire [15:0] progTime = (pgCnt_q == 9'h001) ?
                          16'(`SPFP_BYTE_PROGRAM_CYCLES) :
                          16'(PAGE_PROG_CYCLES);

   // Page buffer capture of each whole data byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pgCnt_q <= 9'h000;
         pgBase_q <= 11'h000;
         pgStartLo_q <= `SPFP_RST_BYTE;
         wrOff_q <= `SPFP_RST_BYTE;
      end else if (clkEn) begin
         if (addrDone) begin
            pgBase_q <= fullAddr[18:8];
            pgStartLo_q <= fullAddr[7:0];
            pgCnt_q <= 9'h000;
            wrOff_q <= `SPFP_RST_BYTE;
         end else if (progByte) begin
            // Offset keeps wrapping so later bytes overwrite older ones
            wrOff_q <= wrOff_q + 8'h01;
            if (pgCnt_q != `SPFP_PAGE_BYTES) begin
               pgCnt_q <= pgCnt_q + 9'h001;
            end
         end
      end
   end

   spfp_page_buf u_page_buf (
      .clock(clock),
      .rst(rst),
      .clkEn(clkEn),
      .wrEn(progByte),
      .wrAddr(bufWrIdx),
      .wrData(rxByte),
      .rdAddr(pgIdx_q),
      .rdData(bufRdData)
   );

   // Latch and flag, set beats clear on the failure flag
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wel_q <= `SPFP_RST_WEL;
         fail_q <= `SPFP_RST_FAIL;
      end else if (clkEn) begin
         if (progStart || progAbort) begin
            wel_q <= 1'b0;
         end else if (holdEnd) begin
            wel_q <= (op_q == `SPFP_OP_WRITE_ENABLE);
         end
         fail_q <= (busy_q && progFail) || (fail_q && !progStart);
      end
   end

   // ****************************************
   // Self-timed program engine and write buffer
   // ****************************************
   wire pop = vld0_q && progReady;
   wire push = rdPend_q;
   wire bufInReady = !vld1_q;
   wire issue = busy_q && (pgLeft_q != 9'h000) && !rdPend_q && bufInReady;
   wire drained = (pgLeft_q == 9'h000) && !rdPend_q && !vld0_q && !vld1_q;
   wire [18:0] pendAddr = {pgBase_q, pgIdx_q - 8'h01};
   wire spfp_pkg::spfp_wr_t pushW = '{addr: pendAddr, data: bufRdData};
   wire load0 = !vld0_q || pop;
   wire load1 = !vld1_q && push && vld0_q && !pop;

   // Busy, timer and buffer walk, only sent bytes go out
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
         tmr_q <= 16'h0000;
         pgLeft_q <= 9'h000;
         pgIdx_q <= `SPFP_RST_BYTE;
         rdPend_q <= 1'b0;
      end else if (clkEn) begin
         if (progStart) begin
            busy_q <= 1'b1;
            tmr_q <= progTime;
            pgLeft_q <= pgCnt_q;
            pgIdx_q <= pgStartLo_q;
         end else begin
            if (tmr_q != 16'h0000) begin
               tmr_q <= tmr_q - 16'h0001;
            end else if (drained) begin
               busy_q <= 1'b0;
            end
            if (issue) begin
               pgLeft_q <= pgLeft_q - 9'h001;
               pgIdx_q <= pgIdx_q + 8'h01;
            end
         end
         rdPend_q <= issue;
      end
   end

   // Two-entry write buffer, stalls the engine through bufInReady
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {vld0_q, vld1_q} <= 2'h0;
         e0_q <= '0;
         e1_q <= '0;
      end else if (clkEn) begin
         vld0_q <= push || vld1_q || (vld0_q && !pop);
         vld1_q <= vld1_q ? !pop : load1;
         if (load0) begin
            e0_q <= vld1_q ? e1_q : pushW;
         end
         if (load1) begin
            e1_q <= pushW;
         end
      end
   end

   assign soOut = so_q;
   assign soOe = soOe_q;
   assign sioOut = sio_q;
   assign sioOe = sioOe_q;
   assign arrayRdAddr = rdAddr_q;
   assign progWord = e0_q;
   assign progValid = vld0_q;
   assign busy = busy_q;
   assign writeEnableLatch = wel_q;
   assign programFailureFlag = fail_q;

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_prog_ok;
      progEnd && progOk;
   endsequence

   sequence s_busy_run;
      busy_q [*8];
   endsequence

   property p_release_off;
      @(posedge clock) disable iff (rst || !clkEn)
      csSync_q |=> !soOe_q && !sioOe_q;
   endproperty
   a_release_off: assert property (p_release_off)
      else $error("data lines driven after release");

   property p_dual_two;
      @(posedge clock) disable iff (rst || !clkEn)
      (shiftOut && dualOut) |=> soOe_q && sioOe_q;
   endproperty
   a_dual_two: assert property (p_dual_two)
      else $error("dual read not driving both lines");

   property p_single_one;
      @(posedge clock) disable iff (rst || !clkEn)
      (shiftOut && !dualOut) |=> soOe_q && !sioOe_q;
   endproperty
   a_single_one: assert property (p_single_one)
      else $error("single read drove second line");

   property p_wrap;
      @(posedge clock) disable iff (rst || !clkEn)
      (loadRead && rdAddr_q == `SPFP_ARRAY_LAST) |=> rdAddr_q == 19'h00000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("address did not wrap to zero");

   property p_start_needs_wel;
      @(posedge clock) disable iff (rst || !clkEn)
      $rose(busy_q) |-> $past(wel_q) && !wel_q;
   endproperty
   a_start_needs_wel: assert property (p_start_needs_wel)
      else $error("program started without latch or kept it");

   property p_abort;
      @(posedge clock) disable iff (rst || !clkEn)
      progAbort |=> !wel_q && !busy_q;
   endproperty
   a_abort: assert property (p_abort)
      else $error("aborted program left latch or busy");

   property p_self_timed;
      @(posedge clock) disable iff (rst || !clkEn)
      s_prog_ok |=> s_busy_run;
   endproperty
   a_self_timed: assert property (p_self_timed)
      else $error("busy ended too soon");

   property p_asi_low;
      @(posedge clock) disable iff (rst || !clkEn)
      (inAsi && csActive && !busy_q) |=> !so_q && soOe_q;
   endproperty
   a_asi_low: assert property (p_asi_low)
      else $error("active status not driven low");

   property p_fail_set;
      @(posedge clock) disable iff (rst || !clkEn)
      (busy_q && progFail) |=> fail_q;
   endproperty
   a_fail_set: assert property (p_fail_set)
      else $error("failure flag not set");

   property p_buf_hold;
      @(posedge clock) disable iff (rst || !clkEn)
      (vld0_q && !progReady) |=> vld0_q && $stable(e0_q);
   endproperty
   a_buf_hold: assert property (p_buf_hold)
      else $error("write word lost under stall");

   property p_ignore_quiet;
      @(posedge clock) disable iff (rst || !clkEn)
      (st_q == spfp_pkg::ST_IGNORE) |-> !soOe_q && !fetchGo;
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet)
      else $error("ignored command produced activity");

endmodule

// [spi_flash_read_and_page_program_tb.sv]
// Purpose: self-checking bench of the read and program sequencer
// Assumes: array model answers one cycle after the address
// Notes: page time shortened to 1000 cycles
`timescale 1ns/1ps
`include "spfp_consts.svh"
module spi_flash_read_and_page_program_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic csN, sck, hostSi, soOut, soOe, sioOut, sioOe, siLine, soLine;
   logic [18:0] arrayRdAddr;
   logic [7:0] arrayRdData = 8'h00;
   spfp_pkg::spfp_wr_t progWord;
   spfp_pkg::spfp_wr_t words[$];
   logic progValid, busy, writeEnableLatch, programFailureFlag;
   logic progFail = 1'b0;
   logic sectorProtected = 1'b0;
   logic stall = 1'b0;
   logic rdyQ = 1'b0;
   logic [7:0] rx;
   int errors = 0;
   int n_checks = 0;
   // ****************************************
   // Design, host and array models
   // ****************************************
   // Released data output shows a changing pattern, released second line carries host data
   assign siLine = sioOe ? sioOut : hostSi;
   assign soLine = soOe ? soOut : rdyQ;
   spfp_host i_spfp_host (.clock(clock), .csN(csN), .sck(sck),
      .si(hostSi), .so(soLine), .second_data_line(siLine));
   spfp_sequencer #(.PAGE_PROG_CYCLES(1000)) i_spfp_sequencer (
      .clock(clock), .rst(rst), .clkEn(1'b1), .csNPin(csN),
      .sckPin(sck), .siPin(siLine), .soOut(soOut), .soOe(soOe),
      .sioOut(sioOut), .sioOe(sioOe), .arrayRdAddr(arrayRdAddr),
      .arrayRdData(arrayRdData), .progWord(progWord),
      .progValid(progValid), .progReady(~stall | rdyQ),
      .progFail(progFail), .sectorProtected(sectorProtected),
      .busy(busy), .writeEnableLatch(writeEnableLatch),
      .programFailureFlag(programFailureFlag));
   // Clock only, reset in main sequence
   initial begin
      forever #20 clock = ~clock;
   end
   // Array data, stalling writer, word capture
   always @(posedge clock) begin
      arrayRdData <= arrayRdAddr[7:0] ^ 8'hA5;
      rdyQ <= ~rdyQ;
      if (progValid && (~stall | rdyQ)) words.push_back(progWord);
   end
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Opcode then three address bytes
   task automatic hdr(input logic [7:0] op, input logic [23:0] a);
      i_spfp_host.open_frame();
      i_spfp_host.shift(op, 8, 1'b0, rx);
      for (int i = 2; i >= 0; i--) i_spfp_host.shift(a[8*i+:8], 8, 1'b0, rx);
   endtask
   task automatic set_latch();
      i_spfp_host.open_frame();
      i_spfp_host.shift(`SPFP_OP_WRITE_ENABLE, 8, 1'b0, rx);
      i_spfp_host.close_frame();
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   // Slow read across the array end, top address bits set
   task automatic t_read_wrap();
      hdr(`SPFP_OP_READ_SLOW, 24'hFFFFFF);
      i_spfp_host.shift(8'h00, 8, 1'b0, rx);
      chk(rx, 8'h5A);
      i_spfp_host.shift(8'h00, 8, 1'b0, rx);
      chk(rx, 8'hA5);
      i_spfp_host.close_frame();
      chk(soOe, 1'b0);
   endtask
   // Fast read with dummy, released mid byte
   task automatic t_read_fast();
      hdr(`SPFP_OP_READ_FAST, 24'h000010);
      i_spfp_host.shift(8'h00, 8, 1'b0, rx);
      i_spfp_host.shift(8'h00, 8, 1'b0, rx);
      chk(rx, 8'hB5);
      i_spfp_host.shift(8'h00, 3, 1'b0, rx);
      i_spfp_host.close_frame();
      chk(soOe, 1'b0);
   endtask
   // Dual read, one byte then half a byte
   task automatic t_read_dual();
      hdr(`SPFP_OP_READ_DUAL, 24'h000020);
      i_spfp_host.shift(8'h00, 8, 1'b0, rx);
      i_spfp_host.shift(8'h00, 4, 1'b1, rx);
      chk(rx, 8'h85);
      i_spfp_host.shift(8'h00, 2, 1'b1, rx);
      i_spfp_host.close_frame();
      chk({soOe, sioOe}, 2'b00);
   endtask
   // Program refused without the latch
   task automatic t_prog_nolatch();
      hdr(`SPFP_OP_PROGRAM, 24'h0000FE);
      i_spfp_host.shift(8'h11, 8, 1'b0, rx);
      i_spfp_host.close_frame();
      chk(busy, 1'b0);
      chk(words.size(), 0);
   endtask
   // Wrapping program, status poll, failure, completion signal
   task automatic t_prog();
      int k;
      set_latch();
      chk(writeEnableLatch, 1'b1);
      #1 stall = 1'b1;
      hdr(`SPFP_OP_PROGRAM, 24'h0000FE);
      for (k = 1; k <= 3; k++) i_spfp_host.shift(8'h11 * k, 8, 1'b0, rx);
      i_spfp_host.close_frame();
      chk({busy, writeEnableLatch}, 2'b10);
      i_spfp_host.open_frame();
      i_spfp_host.shift(`SPFP_OP_STATUS, 8, 1'b0, rx);
      i_spfp_host.shift(8'h00, 8, 1'b0, rx);
      chk(rx[0], 1'b1);
      i_spfp_host.close_frame();
      #1 progFail = 1'b1;
      @(posedge clock);
      #1 progFail = 1'b0;
      i_spfp_host.open_frame();
      i_spfp_host.shift(`SPFP_OP_ACTIVE_STATUS, 8, 1'b0, rx);
      i_spfp_host.shift(8'h00, 8, 1'b0, rx);
      @(posedge clock);
      #1 chk({soOe, soOut}, 2'b11);
      for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clock);
      chk(k < 2000, 1'b1);
      @(posedge clock);
      #1 chk({soOe, soOut}, 2'b10);
      i_spfp_host.close_frame();
      chk(programFailureFlag, 1'b1);
      chk(words.size(), 3);
      for (k = 0; k < 3 && k < words.size(); k++)
         chk(words[k], {11'h0, 8'hFE + 8'(k), 8'(8'h11*(k+1))});
      #1 stall = 1'b0;
   endtask
   // Mid-byte release and protected target both abort
   task automatic t_abort();
      for (int p = 0; p < 2; p++) begin
         words.delete();
         set_latch();
         hdr(`SPFP_OP_PROGRAM, 24'h000100);
         sectorProtected = p[0];
         i_spfp_host.shift(8'hAA, p ? 8 : 5, 1'b0, rx);
         i_spfp_host.close_frame();
         chk({busy, writeEnableLatch}, 2'b00);
         chk(words.size(), 0);
      end
      sectorProtected = 1'b0;
   endtask
   // More than a page: only the last 256 bytes kept
   task automatic t_prog_long();
      int k;
      logic [7:0] d;
      words.delete();
      set_latch();
      hdr(`SPFP_OP_PROGRAM, 24'h000200);
      for (k = 0; k < 258; k++)
         i_spfp_host.shift(8'(k) ^ {k[8], 7'h00}, 8, 1'b0, rx);
      i_spfp_host.close_frame();
      for (k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge clock);
      chk(k < 2000, 1'b1);
      chk(words.size(), 256);
      for (k = 0; k < 3 && k < words.size(); k++) begin
         d = (k < 2) ? (8'h80 | 8'(k)) : 8'(k);
         chk(words[k], {19'h00200 + 19'(k), d});
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clock);
      #1 rst = 1'b0;
      repeat (4) @(posedge clock);
      t_read_wrap();
      t_read_fast();
      t_read_dual();
      t_prog_nolatch();
      t_prog();
      t_abort();
      t_prog_long();
      finish_test();
   end
endmodule
